// >>> hw/psic_pkg.sv
// Package for the port statistics and ingress classifier block.
// Assumes a single 200 MHz clock domain and an APB register bus.
package psic_pkg;
  // Register byte offsets
  localparam logic [11:0] PHY_CTRL_OFS    = 12'h000;
  localparam logic [11:0] PHY_STAT_OFS    = 12'h004;
  localparam logic [11:0] LIF_CTRL_OFS    = 12'h008;
  localparam logic [11:0] FRM_LIM_OFS     = 12'h00c;
  localparam logic [11:0] DEF_COS_OFS     = 12'h010;
  localparam logic [11:0] ETYPE_OFS       = 12'h014;
  localparam logic [11:0] POL_CTRL_OFS    = 12'h020;
  localparam logic [11:0] COMP_OFS        = 12'h024;
  localparam logic [11:0] RATE_THR_OFS    = 12'h028;
  localparam logic [11:0] SEC_OVER_OFS    = 12'h02c;
  localparam logic [11:0] RATE_OFS        = 12'h030;
  localparam logic [11:0] MPLS_TBL_OFS    = 12'h040;
  localparam logic [11:0] PRIO_TBL_OFS    = 12'h060;
  localparam logic [11:0] DSCP_TBL_OFS    = 12'h100;
  localparam logic [11:0] VLAN_TBL_OFS    = 12'h200;
  localparam logic [11:0] CNT_OFS         = 12'h400;
  // Counter indices within a direction
  localparam int CNT_PER_DIR   = 19;
  localparam int C_BYTE_LO     = 0;
  localparam int C_BYTE_HI     = 1;
  localparam int C_FRAMES      = 2;
  localparam int C_MCAST       = 3;
  localparam int C_BCAST       = 4;
  localparam int C_PAUSE       = 5;
  localparam int C_FCS         = 6;
  localparam int C_OVER        = 7;
  localparam int C_UNDER       = 8;
  localparam int C_FRAG        = 9;
  localparam int C_JABBER      = 10;
  localparam int C_HIST0       = 11;
  localparam int C_HIST_VLAN   = 17;
  // Frame lengths
  localparam logic [13:0] LEN_MIN      = 14'd64;
  localparam logic [13:0] LEN_STD_MAX  = 14'd1518;
  localparam logic [13:0] LEN_VLAN_MAX = 14'd1522;
  localparam logic [13:0] FRM_LIM_RST  = 14'd9612;
  // Gap and preamble
  localparam logic [3:0] IFG_MIN   = 4'd6;
  localparam logic [3:0] IFG_RST   = 4'd12;
  localparam logic [3:0] PRE_MIN   = 4'd6;
  localparam logic [3:0] PRE_RST   = 4'd8;
  // Media types
  localparam logic [2:0] MEDIA_COPPER = 3'd0;
  localparam logic [2:0] MEDIA_SFP    = 3'd1;
  localparam logic [2:0] MEDIA_SFPP   = 3'd2;
  localparam logic [2:0] MEDIA_QSFP   = 3'd3;
  localparam logic [2:0] MEDIA_RADIO  = 3'd4;
  // Speeds
  localparam logic [1:0] SPD_100  = 2'd0;
  localparam logic [1:0] SPD_1G   = 2'd1;
  localparam logic [1:0] SPD_10G  = 2'd2;
  // One second at 200 MHz
  localparam int unsigned CLK_HZ  = 200000000;
  localparam int unsigned SEC_S   = 1;
  localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;

  typedef struct packed {
    logic        valid;
    logic        tx;
    logic [13:0] len;
    logic        err;
    logic        vlan;
    logic        mcast;
    logic        bcast;
    logic        pause;
  } psic_frame_t;

  typedef struct packed {
    logic        valid;
    logic        outer_valid;
    logic [11:0] outer_vid;
    logic        outer_is_s;
    logic [2:0]  outer_pcp;
    logic        mpls;
    logic [2:0]  exp;
    logic        ip;
    logic [5:0]  dscp;
    logic [15:0] etype;
    logic        mcast;
    logic        bcast;
    logic [13:0] len;
  } psic_hdr_t;

  typedef struct packed {
    logic        valid;
    logic        pass;
    logic [2:0]  cos;
    logic        yellow;
    logic [5:0]  pol_hit;
    logic [29:0] pol_prof;
    logic [15:0] meter_bytes;
  } psic_cls_t;
endpackage

// >>> hw/psic_top.sv
// Port statistics, physical settings and ingress classifier with APB registers.
// Assumes one clock, frame summaries and parsed headers from the MAC on the same clock.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module psic_top #(
  parameter int unsigned SEC_CYCLES = psic_pkg::SEC_CYC
) (
  input  wire logic                SYS_CLK_I,
  input  wire logic                RESET_N_I,
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [11:0]         PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output logic      [31:0]         PRDATA_O,
  output logic                     PREADY_O,
  output logic                     PSLVERR_O,
  input  wire logic [2:0]          MEDIA_TYPE_I,
  input  wire logic                LINK_UP_I,
  input  wire psic_pkg::psic_frame_t FRAME_I,
  input  wire psic_pkg::psic_hdr_t HDR_I,
  output psic_pkg::psic_cls_t      CLS_O,
  output logic                     AN_EN_O,
  output logic [1:0]               SPEED_O,
  output logic                     FULL_DUPLEX_O,
  output logic                     PAUSE_SYM_O,
  output logic                     PAUSE_ASYM_O,
  output logic [3:0]               IFG_O,
  output logic [3:0]               PREAMBLE_O
);
  localparam int NCNT = 2 * psic_pkg::CNT_PER_DIR;

  // Control registers
  logic [7:0]  phy_ctrl;   // [0] an, [2:1] speed, [3] fd, [4] sym, [5] asym
  logic [3:0]  ifg;
  logic [3:0]  pre;
  logic        lif_admin;
  logic        mpls_trust;
  logic        dscp_trust;
  logic        prio_trust;
  logic [13:0] max_frame_length_limit;
  logic [2:0]  def_cos;
  logic [15:0] etype [3];
  logic [5:0]  pol_en;
  logic [29:0] pol_prof;
  logic [7:0]  comp;
  logic [31:0] rate_thr;
  logic [3:0]  map_mpls [8];
  logic [3:0]  map_cprio [8];
  logic [3:0]  map_sprio [8];
  logic [3:0]  map_dscp [64];
  logic [4:0]  map_vlan [4096];  // [4] hit, [3] yellow, [2:0] cos
  logic [31:0] cnt [NCNT];
  logic [31:0] sec_over;
  logic [31:0] peak_bytes;
  logic [31:0] avg_bytes;
  logic [31:0] peak_pkts;
  logic [31:0] sec_bytes;
  logic [31:0] sec_pkts;
  logic [31:0] sec_cnt;
  logic [31:0] tot_bytes;
  logic [15:0] n_secs;

  wire wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  wire [11:0] a = PADDR_I;

  // Media-limited physical settings
  logic [1:0] eff_speed;
  always_comb
  begin
    eff_speed = phy_ctrl[2:1];
    case (MEDIA_TYPE_I)
      psic_pkg::MEDIA_COPPER: eff_speed = (phy_ctrl[2:1] == psic_pkg::SPD_100)
                                ? psic_pkg::SPD_100 : psic_pkg::SPD_1G;
      psic_pkg::MEDIA_SFP:    eff_speed = psic_pkg::SPD_1G;
      psic_pkg::MEDIA_SFPP:   eff_speed = psic_pkg::SPD_10G;
      psic_pkg::MEDIA_QSFP:   eff_speed = (phy_ctrl[2:1] == psic_pkg::SPD_10G)
                                ? psic_pkg::SPD_10G : psic_pkg::SPD_1G;
      default:                eff_speed = psic_pkg::SPD_10G;
    endcase
  end
  wire fd = (MEDIA_TYPE_I == psic_pkg::MEDIA_COPPER) ? phy_ctrl[3] : 1'b1;
  assign SPEED_O = eff_speed;
  assign FULL_DUPLEX_O = fd;
  assign AN_EN_O = phy_ctrl[0] && (MEDIA_TYPE_I == psic_pkg::MEDIA_COPPER);
  assign PAUSE_SYM_O = phy_ctrl[4] && fd;
  assign PAUSE_ASYM_O = phy_ctrl[5] && fd;
  assign IFG_O = ifg;
  assign PREAMBLE_O = pre;

  // Configuration writes
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      phy_ctrl <= 8'h09;
      ifg <= psic_pkg::IFG_RST;
      pre <= psic_pkg::PRE_RST;
      lif_admin <= 1'b1;
      {mpls_trust, dscp_trust, prio_trust} <= 3'h0;
      max_frame_length_limit <= psic_pkg::FRM_LIM_RST;
      def_cos <= 3'h0;
      etype <= '{default: 16'h0000};
      pol_en <= 6'h00;
      pol_prof <= 30'h0;
      comp <= 8'h00;
      rate_thr <= 32'hffffffff;
    end
    else if (wr_en)
    begin
      case (a)
        psic_pkg::PHY_CTRL_OFS:
        begin
          phy_ctrl <= PWDATA_I[7:0];
          if (PWDATA_I[11:8] >= psic_pkg::IFG_MIN)
            ifg <= PWDATA_I[11:8];
          if (PWDATA_I[15:12] >= psic_pkg::PRE_MIN)
            pre <= PWDATA_I[15:12];
        end
        psic_pkg::LIF_CTRL_OFS:
          {prio_trust, dscp_trust, mpls_trust, lif_admin} <= PWDATA_I[3:0];
        psic_pkg::FRM_LIM_OFS:     max_frame_length_limit <= PWDATA_I[13:0];
        psic_pkg::DEF_COS_OFS:     def_cos <= PWDATA_I[2:0];
        psic_pkg::ETYPE_OFS:       etype[0] <= PWDATA_I[15:0];
        psic_pkg::ETYPE_OFS + 12'h004: etype[1] <= PWDATA_I[15:0];
        psic_pkg::ETYPE_OFS + 12'h008: etype[2] <= PWDATA_I[15:0];
        psic_pkg::POL_CTRL_OFS:
        begin
          pol_en <= PWDATA_I[5:0];
          pol_prof <= {4'h0, PWDATA_I[31:6]};
        end
        psic_pkg::COMP_OFS:        comp <= PWDATA_I[7:0];
        psic_pkg::RATE_THR_OFS:    rate_thr <= PWDATA_I;
        default:                   ;
      endcase
    end
  end

  // Classification tables
  always_ff @(posedge SYS_CLK_I)
  begin
    if (wr_en && a[11:5] == psic_pkg::MPLS_TBL_OFS[11:5])
      map_mpls[a[4:2]] <= PWDATA_I[3:0];
    if (wr_en && a[11:5] == psic_pkg::PRIO_TBL_OFS[11:5])
      map_cprio[a[4:2]] <= PWDATA_I[3:0];
    if (wr_en && a[11:5] == psic_pkg::PRIO_TBL_OFS[11:5] + 7'h01)
      map_sprio[a[4:2]] <= PWDATA_I[3:0];
    if (wr_en && a[11:8] == psic_pkg::DSCP_TBL_OFS[11:8])
      map_dscp[a[7:2]] <= PWDATA_I[3:0];
    if (wr_en && a[11:9] == psic_pkg::VLAN_TBL_OFS[11:9])
      map_vlan[{PWDATA_I[27:16]}] <= PWDATA_I[4:0];
  end

  // Ingress classification
  logic [3:0] cls_map;
  logic       cls_hit;
  always_comb
  begin
    cls_map = {1'b0, def_cos};
    cls_hit = 1'b0;
    if (HDR_I.mpls && mpls_trust)
    begin
      cls_map = map_mpls[HDR_I.exp];
      cls_hit = 1'b1;
    end
    else if (!HDR_I.mpls && HDR_I.ip && dscp_trust)
    begin
      cls_map = map_dscp[HDR_I.dscp];
      cls_hit = 1'b1;
    end
    if (!cls_hit && prio_trust && HDR_I.outer_valid)
      cls_map = HDR_I.outer_is_s ? map_sprio[HDR_I.outer_pcp]
                                 : map_cprio[HDR_I.outer_pcp];
    if (HDR_I.outer_valid && map_vlan[HDR_I.outer_vid][4])
      cls_map = map_vlan[HDR_I.outer_vid][3:0];
  end

  logic [5:0] pol_match;
  always_comb
  begin
    pol_match[0] = !HDR_I.mcast && !HDR_I.bcast;
    pol_match[1] = HDR_I.mcast && !HDR_I.bcast;
    pol_match[2] = HDR_I.bcast;
    for (int i = 0; i < 3; i++)
      pol_match[3 + i] = (HDR_I.etype == etype[i]);
  end

  // Link pin resynchronised; a change counts once stages two and three agree
  logic [2:0] link_sync;
  logic       link_up;
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      {link_up, link_sync} <= 4'h0;
    else
    begin
      link_sync <= {link_sync[1:0], LINK_UP_I};
      if (link_sync[1] == link_sync[2])
        link_up <= link_sync[2];
    end
  end
  wire lif_oper = lif_admin && link_up;
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      CLS_O <= '0;
    else
    begin
      CLS_O.valid <= HDR_I.valid;
      CLS_O.pass <= lif_oper;
      CLS_O.cos <= cls_map[2:0];
      CLS_O.yellow <= cls_map[3];
      CLS_O.pol_hit <= pol_match & pol_en;
      CLS_O.pol_prof <= pol_prof;
      CLS_O.meter_bytes <= {2'b00, HDR_I.len} + {8'h00, comp};
    end
  end

  // Frame statistics
  wire [13:0] std_max = FRAME_I.vlan ? psic_pkg::LEN_VLAN_MAX : psic_pkg::LEN_STD_MAX;
  wire        is_long = FRAME_I.len > std_max;
  wire        is_short = FRAME_I.len < psic_pkg::LEN_MIN;
  logic [psic_pkg::CNT_PER_DIR-1:0] inc;
  always_comb
  begin
    inc = '0;
    inc[psic_pkg::C_FRAMES] = 1'b1;
    inc[psic_pkg::C_MCAST] = FRAME_I.mcast && !FRAME_I.err;
    inc[psic_pkg::C_BCAST] = FRAME_I.bcast && !FRAME_I.err;
    inc[psic_pkg::C_PAUSE] = FRAME_I.pause;
    inc[psic_pkg::C_FCS] = FRAME_I.err;
    inc[psic_pkg::C_OVER] = !FRAME_I.err && (is_long ||
      (!FRAME_I.tx && FRAME_I.len > max_frame_length_limit));
    inc[psic_pkg::C_UNDER] = is_short && !FRAME_I.err;
    inc[psic_pkg::C_FRAG] = is_short && FRAME_I.err;
    inc[psic_pkg::C_JABBER] = is_long && FRAME_I.err;
    inc[psic_pkg::C_HIST0] = FRAME_I.len == psic_pkg::LEN_MIN;
    inc[psic_pkg::C_HIST0 + 1] = FRAME_I.len > 14'd64 && FRAME_I.len < 14'd128;
    inc[psic_pkg::C_HIST0 + 2] = FRAME_I.len >= 14'd128 && FRAME_I.len < 14'd256;
    inc[psic_pkg::C_HIST0 + 3] = FRAME_I.len >= 14'd256 && FRAME_I.len < 14'd512;
    inc[psic_pkg::C_HIST0 + 4] = FRAME_I.len >= 14'd512 && FRAME_I.len < 14'd1024;
    inc[psic_pkg::C_HIST0 + 5] = FRAME_I.len >= 14'd1024 &&
                                 FRAME_I.len <= psic_pkg::LEN_STD_MAX;
    inc[psic_pkg::C_HIST_VLAN] = FRAME_I.len > psic_pkg::LEN_STD_MAX &&
      FRAME_I.len <= psic_pkg::LEN_VLAN_MAX && (FRAME_I.tx || FRAME_I.vlan);
  end

  wire [32:0] lo_sum = {1'b0, cnt[FRAME_I.tx ? psic_pkg::CNT_PER_DIR : 0]}
                       + {19'h0, FRAME_I.len};
  genvar g;
  generate
    for (g = 0; g < NCNT; g++)
    begin : g_cnt
      localparam int IDX = g % psic_pkg::CNT_PER_DIR;
      localparam logic DIR_TX = (g >= psic_pkg::CNT_PER_DIR);
      always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
          cnt[g] <= 32'h00000000;
        else if (FRAME_I.valid && FRAME_I.tx == DIR_TX)
        begin
          if (IDX == psic_pkg::C_BYTE_LO)
            cnt[g] <= lo_sum[31:0];
          else if (IDX == psic_pkg::C_BYTE_HI)
            cnt[g] <= cnt[g] + {31'h0, lo_sum[32]};
          else if (inc[IDX])
            cnt[g] <= cnt[g] + 32'h00000001;
        end
      end
    end
  endgenerate

  // Per-second rate monitor
  wire sec_tick = sec_cnt == SEC_CYCLES - 1;
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sec_cnt <= 32'h0;
      sec_bytes <= 32'h0;
      sec_pkts <= 32'h0;
      peak_bytes <= 32'h0;
      peak_pkts <= 32'h0;
      tot_bytes <= 32'h0;
      avg_bytes <= 32'h0;
      n_secs <= 16'h0;
      sec_over <= 32'h0;
    end
    else
    begin
      sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
      if (sec_tick)
      begin
        sec_bytes <= FRAME_I.valid ? {18'h0, FRAME_I.len} : 32'h0;
        sec_pkts <= {31'h0, FRAME_I.valid};
        if (sec_bytes > peak_bytes)
          peak_bytes <= sec_bytes;
        if (sec_pkts > peak_pkts)
          peak_pkts <= sec_pkts;
        tot_bytes <= tot_bytes + sec_bytes;
        n_secs <= n_secs + 16'h1;
        avg_bytes <= (tot_bytes + sec_bytes) / {16'h0, n_secs + 16'h1};
        if (sec_bytes > rate_thr)
          sec_over <= sec_over + 32'h1;
      end
      else if (FRAME_I.valid)
      begin
        sec_bytes <= sec_bytes + {18'h0, FRAME_I.len};
        sec_pkts <= sec_pkts + 32'h1;
      end
    end
  end

  // APB read path, zero wait states
  always_comb
  begin
    PRDATA_O = 32'h0;
    case (a)
      psic_pkg::PHY_CTRL_OFS:    PRDATA_O = {16'h0, pre, ifg, phy_ctrl};
      psic_pkg::PHY_STAT_OFS:    PRDATA_O = {24'h0, PAUSE_ASYM_O, PAUSE_SYM_O,
                                   link_up, fd, eff_speed, AN_EN_O, lif_oper};
      psic_pkg::LIF_CTRL_OFS:    PRDATA_O = {28'h0, prio_trust, dscp_trust,
                                             mpls_trust, lif_admin};
      psic_pkg::FRM_LIM_OFS:     PRDATA_O = {18'h0, max_frame_length_limit};
      psic_pkg::DEF_COS_OFS:     PRDATA_O = {29'h0, def_cos};
      psic_pkg::POL_CTRL_OFS:    PRDATA_O = {pol_prof[25:0], pol_en};
      psic_pkg::COMP_OFS:        PRDATA_O = {24'h0, comp};
      psic_pkg::RATE_THR_OFS:    PRDATA_O = rate_thr;
      psic_pkg::SEC_OVER_OFS:    PRDATA_O = sec_over;
      psic_pkg::RATE_OFS:        PRDATA_O = peak_bytes;
      psic_pkg::RATE_OFS + 12'h004: PRDATA_O = avg_bytes;
      psic_pkg::RATE_OFS + 12'h008: PRDATA_O = peak_pkts;
      default:
        if (a >= psic_pkg::CNT_OFS && a < psic_pkg::CNT_OFS + 12'(NCNT * 4))
          PRDATA_O = cnt[6'(a[7:2])];
    endcase
  end
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
endmodule

// >>> sim/psic_props.sv
// Checker for the port statistics and ingress classifier top.
// Sees only top ports; bound from the bench top file.
`timescale 1ns/1ps
module psic_props (
  input wire logic                  SYS_CLK_I,
  input wire logic                  RESET_N_I,
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [11:0]           PADDR_I,
  input wire logic [31:0]           PWDATA_I,
  input wire logic [2:0]            MEDIA_TYPE_I,
  input wire psic_pkg::psic_hdr_t   HDR_I,
  input wire psic_pkg::psic_cls_t   CLS_O,
  input wire logic                  AN_EN_O,
  input wire logic [1:0]            SPEED_O,
  input wire logic                  FULL_DUPLEX_O,
  input wire logic                  PAUSE_SYM_O,
  input wire logic                  PAUSE_ASYM_O,
  input wire logic [3:0]            IFG_O,
  input wire logic [3:0]            PREAMBLE_O
);
  logic phy_wr;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  assign phy_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == psic_pkg::PHY_CTRL_OFS;
  chk_an_forced: assert property (
    MEDIA_TYPE_I != psic_pkg::MEDIA_COPPER |-> !AN_EN_O) else $error("negotiation not off");
  chk_radio_fixed: assert property (
    MEDIA_TYPE_I >= psic_pkg::MEDIA_RADIO |-> SPEED_O == psic_pkg::SPD_10G && FULL_DUPLEX_O)
    else $error("radio port not 10G full duplex");
  chk_sfp_speed: assert property (
    MEDIA_TYPE_I == psic_pkg::MEDIA_SFP |-> SPEED_O == psic_pkg::SPD_1G)
    else $error("sfp speed not 1G");
  chk_sfpp_speed: assert property (
    MEDIA_TYPE_I == psic_pkg::MEDIA_SFPP |-> SPEED_O == psic_pkg::SPD_10G)
    else $error("sfp plus speed not 10G");
  chk_pause_fd: assert property (
    PAUSE_SYM_O || PAUSE_ASYM_O |-> FULL_DUPLEX_O) else $error("pause in half duplex");
  chk_ifg_hold: assert property (
    phy_wr && PWDATA_I[11:8] < 4'd6 |=> $stable(IFG_O)) else $error("gap below 6 taken");
  chk_pre_hold: assert property (
    phy_wr && PWDATA_I[15:12] < 4'd6 |=> $stable(PREAMBLE_O)) else $error("preamble below 6");
  chk_cls_timing: assert property (
    CLS_O.valid == $past(HDR_I.valid)) else $error("class result not one cycle after header");
  chk_uc_policer: assert property (
    CLS_O.valid && CLS_O.pol_hit[0] |-> !$past(HDR_I.mcast) && !$past(HDR_I.bcast))
    else $error("unicast policer on non-unicast");
  cover property (HDR_I.valid && HDR_I.mpls);
  cover property (phy_wr && PWDATA_I[11:8] < 4'd6);
  cover property (MEDIA_TYPE_I >= psic_pkg::MEDIA_RADIO);
endmodule

// >>> sim/psic_peer.sv
// Network side model: frame summaries and parsed ingress headers.
// Drives right after rising edges; fields scramble while idle.
`timescale 1ns/1ps
module psic_peer (
  input  wire logic            clk_i,
  output psic_pkg::psic_frame_t frame_o,
  output psic_pkg::psic_hdr_t  hdr_o
);
  initial
  begin
    frame_o = '0;
    hdr_o = '0;
  end
  task automatic send_frame(input psic_pkg::psic_frame_t f);
    @(posedge clk_i);
    frame_o <= f;
    @(posedge clk_i);
    frame_o <= {1'b0, ~f[19:0]};
  endtask
  task automatic send_hdr(input psic_pkg::psic_hdr_t h);
    @(posedge clk_i);
    hdr_o <= h;
    @(posedge clk_i);
    hdr_o <= {1'b0, ~h[59:0]};
  endtask
endmodule

// >>> sim/psic_top_test.sv
// Self-checking bench: media rules, gap and preamble, counters, classifier.
// Assumes PREADY_O answers in the access cycle; one 200 MHz clock.
`timescale 1ns/1ps
module psic_top_test;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rdata;
  logic [2:0]  media;
  logic        link;
  wire  [31:0] prdata;
  wire         pready;
  wire         an;
  wire         fd;
  wire         psym;
  wire         pasym;
  wire  [1:0]  spd;
  wire  [3:0]  ifg;
  wire  [3:0]  pre;
  int          num_errors;
  int          n_tests;
  int          cyc;
  logic [1:0]  es [1:4] = '{2'd1, 2'd2, 2'd2, 2'd2};
  int er [18] = '{6047, 0, 8, 1, 1, 1, 2, 3, 1, 1, 1, 2, 0, 0, 0, 0, 1, 1};
  int et [18] = '{2720, 0, 2, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
  psic_pkg::psic_frame_t frm;
  psic_pkg::psic_hdr_t   hdr;
  psic_pkg::psic_cls_t   cls;
  psic_top #(.SEC_CYCLES(100)) u_psic_top (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(), .MEDIA_TYPE_I(media), .LINK_UP_I(link), .FRAME_I(frm), .HDR_I(hdr),
    .CLS_O(cls), .AN_EN_O(an), .SPEED_O(spd), .FULL_DUPLEX_O(fd), .PAUSE_SYM_O(psym),
    .PAUSE_ASYM_O(pasym), .IFG_O(ifg), .PREAMBLE_O(pre));
  psic_peer u_psic_peer (.clk_i(clk), .frame_o(frm), .hdr_o(hdr));
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e & m);
  endtask
  function automatic psic_pkg::psic_frame_t fr(input logic t, input logic [13:0] l,
                                               input logic [4:0] f);
    return {1'b1, t, l, f};
  endfunction
  // v: outer valid, vid, S-tag, pcp; q: mpls, exp, ip, dscp; e: ethertype, mcast, bcast
  function automatic psic_pkg::psic_hdr_t hd(input logic [16:0] v, input logic [10:0] q,
                                             input logic [17:0] e);
    return {1'b1, v, q, e, 14'd100};
  endfunction
  task automatic cl(input psic_pkg::psic_hdr_t h, input logic [26:0] e);
    u_psic_peer.send_hdr(h);
    #1;
    chk({cls.pass, cls.cos, cls.yellow, cls.pol_hit, cls.meter_bytes}, e);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    media = 3'h0;
    link = 1'b1;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({ifg, pre}, 8'hc8);
    rd_chk(psic_pkg::PHY_CTRL_OFS, 32'h8c09, 32'hff09);
    rd_chk(12'hffc, 32'h0, 32'hffffffff);
    wr(psic_pkg::PHY_CTRL_OFS, 32'h8c39);
    chk({an, spd, fd, psym, pasym}, 6'b100111);
    wr(psic_pkg::PHY_CTRL_OFS, 32'h8c31);
    chk({psym, pasym}, 2'b00);
    wr(psic_pkg::PHY_CTRL_OFS, 32'h8c1d);
    for (int m = 1; m <= 4; m++)
    begin
      @(posedge clk);
      media <= 3'(m);
      #1;
      chk({an, spd}, {1'b0, es[m]});
    end
    wr(psic_pkg::PHY_CTRL_OFS, 32'h8c15);
    chk({fd, spd}, 3'b110);
    @(posedge clk);
    media <= 3'h0;
    wr(psic_pkg::PHY_CTRL_OFS, 32'h8509);
    chk(ifg, 4'hc);
    wr(psic_pkg::PHY_CTRL_OFS, 32'h6f09);
    chk({ifg, pre}, 8'hf6);
    wr(psic_pkg::PHY_CTRL_OFS, 32'h5609);
    chk({ifg, pre}, 8'h66);
    wr(psic_pkg::FRM_LIM_OFS, 32'd1000);
    u_psic_peer.send_frame(fr(1'b0, 14'd64, 5'b00100));
    u_psic_peer.send_frame(fr(1'b0, 14'd1600, 5'b10000));
    u_psic_peer.send_frame(fr(1'b0, 14'd1520, 5'b01000));
    u_psic_peer.send_frame(fr(1'b0, 14'd40, 5'b00010));
    u_psic_peer.send_frame(fr(1'b0, 14'd40, 5'b10000));
    u_psic_peer.send_frame(fr(1'b0, 14'd1519, 5'b00000));
    u_psic_peer.send_frame(fr(1'b0, 14'd64, 5'b00001));
    u_psic_peer.send_frame(fr(1'b0, 14'd1200, 5'b00000));
    u_psic_peer.send_frame(fr(1'b1, 14'd1520, 5'b00000));
    u_psic_peer.send_frame(fr(1'b1, 14'd1200, 5'b00000));
    for (int i = 0; i < 18; i++)
    begin
      rd_chk(psic_pkg::CNT_OFS + 12'(4 * i), 32'(er[i]), '1);
      rd_chk(psic_pkg::CNT_OFS + 12'(4 * (19 + i)), 32'(et[i]), '1);
    end
    wr(psic_pkg::DEF_COS_OFS, 32'd5);
    wr(psic_pkg::COMP_OFS, 32'd20);
    wr(psic_pkg::MPLS_TBL_OFS + 12'd12, 32'ha);
    wr(psic_pkg::DSCP_TBL_OFS + 12'd40, 32'h6);
    wr(psic_pkg::PRIO_TBL_OFS + 12'd16, 32'h9);
    wr(psic_pkg::PRIO_TBL_OFS + 12'd48, 32'h3);
    wr(psic_pkg::LIF_CTRL_OFS, 32'h1);
    cl(hd(17'h0, 11'h4a, 18'h2002), {1'b1, 3'd5, 1'b0, 6'h0, 16'd120});
    wr(psic_pkg::LIF_CTRL_OFS, 32'h5);
    cl(hd(17'h0, 11'h5ca, 18'h2002), {1'b1, 3'd5, 1'b0, 6'h0, 16'd120});
    wr(psic_pkg::LIF_CTRL_OFS, 32'hf);
    cl(hd(17'h0, 11'h5ca, 18'h2002), {1'b1, 3'd2, 1'b1, 6'h0, 16'd120});
    cl(hd(17'h0, 11'h4a, 18'h2002), {1'b1, 3'd6, 1'b0, 6'h0, 16'd120});
    cl(hd(17'h10644, 11'h0, 18'h2002), {1'b1, 3'd1, 1'b1, 6'h0, 16'd120});
    cl(hd(17'h1064c, 11'h0, 18'h2002), {1'b1, 3'd3, 1'b0, 6'h0, 16'd120});
    wr(psic_pkg::VLAN_TBL_OFS, 32'h0064001f);
    cl(hd(17'h1064c, 11'h5ca, 18'h2002), {1'b1, 3'd7, 1'b1, 6'h0, 16'd120});
    wr(psic_pkg::ETYPE_OFS, 32'h0806);
    wr(psic_pkg::POL_CTRL_OFS, 32'h9);
    cl(hd(17'h0, 11'h0, 18'h2018), {1'b1, 3'd5, 1'b0, 6'h09, 16'd120});
    cl(hd(17'h0, 11'h0, 18'h2002), {1'b1, 3'd5, 1'b0, 6'h00, 16'd120});
    wr(psic_pkg::POL_CTRL_OFS, 32'h3f);
    rd_chk(psic_pkg::POL_CTRL_OFS, 32'h3f, '1);
    cl(hd(17'h0, 11'h0, 18'h2019), {1'b1, 3'd5, 1'b0, 6'h0c, 16'd120});
    wr(psic_pkg::LIF_CTRL_OFS, 32'h0);
    u_psic_peer.send_hdr(hd(17'h0, 11'h0, 18'h2018));
    #1;
    chk(cls.pass, 1'b0);
    wr(psic_pkg::LIF_CTRL_OFS, 32'h1);
    rd_chk(psic_pkg::PHY_STAT_OFS, 32'h21, 32'h21);
    @(posedge clk);
    link <= 1'b0;
    repeat (4) @(posedge clk);
    u_psic_peer.send_hdr(hd(17'h0, 11'h0, 18'h2018));
    #1;
    chk(cls.pass, 1'b0);
    rd_chk(psic_pkg::PHY_STAT_OFS, 32'h00, 32'h21);
    end_sim();
  end
endmodule
bind psic_top psic_props u_psic_props (.*);
